/* pifb_top.sv */
// peripheral interrupt flag bank for flag groups three and four
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pifb_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        capcomp_three_evt,
  input  wire logic        capcomp_four_evt,
  input  wire logic        timer_six_match,
  input  wire logic        timer_four_match,
  input  wire logic        serial_two_done,
  input  wire logic        serial_two_collision,
  output logic             periph_irq_req,
  output logic             irq
);
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic        rd_now;
  logic [11:0] rd_addr;
  logic [7:0]  flag_reg_three;
  logic [7:0]  flag_reg_four;
  logic [7:0]  enable_reg_three;
  logic [7:0]  enable_reg_four;
  logic [7:0]  irq_control_reg;
  logic [1:0]  event_status;
  logic [1:0]  event_mask;
  logic        req_d;

  pifb_ahb_slave u_slave (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hready  (hready),
    .wr_pend (wr_pend),
    .wr_addr (wr_addr),
    .rd_now  (rd_now),
    .rd_addr (rd_addr)
  );

  // write strobes, data taken in the data phase
  wire wr_three  = wr_pend & (wr_addr == pifb_pkg::flag_three_off);
  wire wr_four   = wr_pend & (wr_addr == pifb_pkg::flag_four_off)
                   & LARGE_VARIANT;
  wire wr_en3    = wr_pend & (wr_addr == pifb_pkg::enable_three_off);
  wire wr_en4    = wr_pend & (wr_addr == pifb_pkg::enable_four_off)
                   & LARGE_VARIANT;
  wire wr_ctrl   = wr_pend & (wr_addr == pifb_pkg::irq_ctrl_off);
  wire wr_status = wr_pend & (wr_addr == pifb_pkg::status_off);
  wire wr_mask   = wr_pend & (wr_addr == pifb_pkg::mask_off);

  // event inputs routed onto flag bit positions
  wire [7:0] set_three = (8'(capcomp_four_evt) << pifb_pkg::capcomp_four_bit)
                   | (8'(capcomp_three_evt) << pifb_pkg::capcomp_three_bit)
                   | (8'(timer_six_match) << pifb_pkg::timer_six_bit)
                   | (8'(timer_four_match) << pifb_pkg::timer_four_bit);
  wire [7:0] set_four  = {8{LARGE_VARIANT}}
    & ((8'(serial_two_collision) << pifb_pkg::serial_coll_bit)
    | (8'(serial_two_done) << pifb_pkg::serial_done_bit));

  // only implemented bits get a flip-flop; the rest tie to zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flags
      if (pifb_pkg::three_impl_mask[gi]) begin : g_three
        pifb_flag_bit u_bit (
          .hclk    (hclk),
          .hresetn (hresetn),
          .set_evt (set_three[gi]),
          .wr_en   (wr_three),
          .wr_val  (hwdata[gi]),
          .flag    (flag_reg_three[gi])
        );
      end else begin : g_three_none
        assign flag_reg_three[gi] = 1'b0;
      end
      if (pifb_pkg::four_impl_mask[gi]) begin : g_four
        pifb_flag_bit u_bit (
          .hclk    (hclk),
          .hresetn (hresetn),
          .set_evt (set_four[gi]),
          .wr_en   (wr_four),
          .wr_val  (hwdata[gi]),
          .flag    (flag_reg_four[gi])
        );
      end else begin : g_four_none
        assign flag_reg_four[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg_three <= pifb_pkg::enable_reset;
      enable_reg_four  <= pifb_pkg::enable_reset;
      irq_control_reg  <= pifb_pkg::enable_reset;
      event_mask       <= pifb_pkg::event_reset;
    end else begin
      if (wr_en3) enable_reg_three <= hwdata[7:0] & pifb_pkg::three_impl_mask;
      if (wr_en4) enable_reg_four  <= hwdata[7:0] & pifb_pkg::four_impl_mask;
      if (wr_ctrl) irq_control_reg <= hwdata[7:0] & pifb_pkg::ctrl_impl_mask;
      if (wr_mask) event_mask <= hwdata[1:0];
    end
  end

  // request: any flag with its enable, gated by peripheral and global enable
  wire any_pending = |(flag_reg_three & enable_reg_three)
                   | |(flag_reg_four & enable_reg_four);
  wire next_req    = any_pending
                   & irq_control_reg[pifb_pkg::periph_en_bit]
                   & irq_control_reg[pifb_pkg::global_en_bit];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_irq_req <= 1'b0;
      req_d          <= 1'b0;
    end else begin
      periph_irq_req <= next_req;
      req_d          <= periph_irq_req;
    end
  end

  // status: bit0 request level seen, bit1 request rising edge; w1c
  wire [1:0] status_set = {periph_irq_req & ~req_d, periph_irq_req};
  wire [1:0] status_clr = wr_status ? hwdata[1:0] : 2'b00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status <= pifb_pkg::event_reset;
    end else begin
      // set wins over a write-one clear in the same cycle
      event_status <= status_set | (event_status & ~status_clr);
    end
  end

  assign irq = |(event_status & event_mask);

  // small variant: group four reads zero even if a flop were left behind
  wire [7:0] flag_four_rd   = LARGE_VARIANT ? flag_reg_four : 8'h00;
  wire [7:0] enable_four_rd = LARGE_VARIANT ? enable_reg_four : 8'h00;

  // read mux; unmapped offsets read zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (rd_addr)
      pifb_pkg::flag_three_off:   rd_byte = flag_reg_three;
      pifb_pkg::flag_four_off:    rd_byte = flag_four_rd;
      pifb_pkg::enable_three_off: rd_byte = enable_reg_three;
      pifb_pkg::enable_four_off:  rd_byte = enable_four_rd;
      pifb_pkg::irq_ctrl_off:     rd_byte = irq_control_reg;
      pifb_pkg::status_off:       rd_byte = {6'h00, event_status};
      pifb_pkg::mask_off:         rd_byte = {6'h00, event_mask};
      pifb_pkg::pending_off:      rd_byte = {7'h00, periph_irq_req};
      pifb_pkg::variant_off:      rd_byte = {7'h00, LARGE_VARIANT};
      default:                    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_now) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks
  timer_six_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_six_match |=> flag_reg_three[pifb_pkg::timer_six_bit])
    else $error("timer six flag not set");
  timer_four_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_four_match |=> flag_reg_three[pifb_pkg::timer_four_bit])
    else $error("timer four flag not set");
  capcomp_three_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    capcomp_three_evt |=> flag_reg_three[pifb_pkg::capcomp_three_bit])
    else $error("capture three flag not set");
  capcomp_four_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    capcomp_four_evt |=> flag_reg_three[pifb_pkg::capcomp_four_bit])
    else $error("capture four flag not set");
  unimpl_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((flag_reg_three & ~pifb_pkg::three_impl_mask) == 8'h00)
    && ((flag_reg_four & ~pifb_pkg::four_impl_mask) == 8'h00))
    else $error("unimplemented flag bit set");
  rd_upper_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_now |=> (hrdata[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");
  set_beats_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (capcomp_three_evt && wr_three)
    |=> flag_reg_three[pifb_pkg::capcomp_three_bit])
    else $error("event lost on clear");

  coll_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (serial_two_collision && LARGE_VARIANT)
    |=> flag_reg_four[pifb_pkg::serial_coll_bit])
    else $error("collision flag not set");
  coll_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flag_reg_four[pifb_pkg::serial_coll_bit] && !wr_four)
    |=> flag_reg_four[pifb_pkg::serial_coll_bit])
    else $error("collision flag dropped");
  coll_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_four && !hwdata[pifb_pkg::serial_coll_bit] && !serial_two_collision)
    |=> !flag_reg_four[pifb_pkg::serial_coll_bit])
    else $error("collision flag not cleared");
  done_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (serial_two_done && LARGE_VARIANT)
    |=> flag_reg_four[pifb_pkg::serial_done_bit])
    else $error("done flag not set");
  done_flag_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (serial_two_done && LARGE_VARIANT) ##1 !wr_four [*2]
    |-> flag_reg_four[pifb_pkg::serial_done_bit])
    else $error("done flag not held");
  done_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_four && !hwdata[pifb_pkg::serial_done_bit] && !serial_two_done)
    |=> !flag_reg_four[pifb_pkg::serial_done_bit])
    else $error("done flag not cleared");

  reset_clear_a: assert property (
    @(posedge hclk)
    $rose(hresetn) |-> (flag_reg_three == 8'h00 && flag_reg_four == 8'h00))
    else $error("flags not clear after reset");
  variant_absent_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !LARGE_VARIANT |-> (flag_reg_four == 8'h00))
    else $error("flag four on small variant");
  enable_absent_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !LARGE_VARIANT |-> (enable_reg_four == 8'h00))
    else $error("enable four on small variant");

  req_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    next_req |=> periph_irq_req ##1 (status_set[0] || event_status[0]))
    else $error("request not raised");
  no_req_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !irq_control_reg[pifb_pkg::global_en_bit] |=> !periph_irq_req)
    else $error("request with global off");
  periph_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !irq_control_reg[pifb_pkg::periph_en_bit] |=> !periph_irq_req)
    else $error("request with peripheral enable off");
  req_drop_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !next_req |=> !periph_irq_req)
    else $error("request held without cause");
  status_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (periph_irq_req && !req_d) |=> event_status[pifb_pkg::status_edge_bit])
    else $error("request edge not recorded");
  status_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_status && hwdata[pifb_pkg::status_irq_bit] && !periph_irq_req)
    |=> !event_status[pifb_pkg::status_irq_bit])
    else $error("status bit not cleared");

  cov_req_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(periph_irq_req));
  cov_irq_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));
  cov_clear_c: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_three && flag_reg_three != 8'h00);
  cov_collide_c: cover property (@(posedge hclk) disable iff (!hresetn)
    capcomp_three_evt && wr_three);
  cov_coll_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(flag_reg_four[pifb_pkg::serial_coll_bit]));
endmodule : pifb_top

/* pifb_pkg.sv */
// package of register map, field positions and reset values for the flag bank
package pifb_pkg;
  localparam logic [11:0] flag_three_off   = 12'h000;
  localparam logic [11:0] flag_four_off    = 12'h004;
  localparam logic [11:0] enable_three_off = 12'h008;
  localparam logic [11:0] enable_four_off  = 12'h00C;
  localparam logic [11:0] irq_ctrl_off     = 12'h010;
  localparam logic [11:0] status_off       = 12'h014;
  localparam logic [11:0] mask_off         = 12'h018;
  localparam logic [11:0] pending_off      = 12'h01C;
  localparam logic [11:0] variant_off      = 12'h020;

  localparam int timer_four_bit   = 1;
  localparam int timer_six_bit    = 3;
  localparam int capcomp_three_bit = 4;
  localparam int capcomp_four_bit  = 5;
  localparam int serial_done_bit  = 0;
  localparam int serial_coll_bit  = 1;
  localparam int global_en_bit    = 7;
  localparam int periph_en_bit    = 6;

  localparam logic [7:0] three_impl_mask = 8'h3A;
  localparam logic [7:0] four_impl_mask  = 8'h03;
  localparam logic [7:0] ctrl_impl_mask  = 8'hC0;
  localparam logic [7:0] flag_reset      = 8'h00;
  localparam logic [7:0] enable_reset    = 8'h00;
  localparam logic [1:0] event_reset     = 2'h0;
  localparam logic [1:0] event_impl_mask = 2'h3;
  localparam int         status_irq_bit  = 0;
  localparam int         status_edge_bit = 1;
endpackage : pifb_pkg

/* pifb_flag_bit.sv */
// one sticky flag bit: hardware set wins over software clear
`timescale 1ns/1ps
module pifb_flag_bit (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_evt,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      flag
);
  wire next_flag = set_evt | (wr_en ? wr_val : flag);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule : pifb_flag_bit

/* pifb_ahb_slave.sv */
// ahb-lite slave front end: captures the address phase, zero wait states
`timescale 1ns/1ps
module pifb_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  output logic             wr_pend,
  output logic [11:0]      wr_addr,
  output logic             rd_now,
  output logic [11:0]      rd_addr
);
  wire valid_req = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= valid_req & hwrite & (hsize == 3'h2);
      wr_addr <= haddr;
    end
  end

  assign rd_now  = valid_req & ~hwrite;
  assign rd_addr = haddr;
endmodule : pifb_ahb_slave

/* pifb_event_src.sv */
// behavioural model of the six peripheral event sources
`timescale 1ns/1ps
module pifb_event_src (
  input  wire logic hclk,
  output logic      capcomp_three_evt,
  output logic      capcomp_four_evt,
  output logic      timer_six_match,
  output logic      timer_four_match,
  output logic      serial_two_done,
  output logic      serial_two_collision
);
  logic [5:0] evt;
  initial evt = 6'h00;
  assign {serial_two_collision, serial_two_done, timer_four_match,
          timer_six_match, capcomp_four_evt, capcomp_three_evt} = evt;
  // a source fires once and drops again; the flag bank must hold the flag
  task automatic pulse(input int idx);
    @(posedge hclk);
    evt[idx] <= 1'b1;
    @(posedge hclk);
    evt[idx] <= 1'b0;
  endtask : pulse
endmodule : pifb_event_src

/* peripheral_irq_flag_bank_tb.sv */
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ps
module peripheral_irq_flag_bank_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        cc3, cc4, t6, t4, sdone, scoll;
  logic        periph_irq_req;
  logic        irq;
  logic [31:0] s_hrdata;
  int          mismatches;
  int          checked;

  pifb_top u_pifb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capcomp_three_evt(cc3),
    .capcomp_four_evt(cc4), .timer_six_match(t6), .timer_four_match(t4),
    .serial_two_done(sdone), .serial_two_collision(scoll),
    .periph_irq_req(periph_irq_req), .irq(irq));
  // second copy built as the small variant: group four must stay dark
  pifb_top #(.LARGE_VARIANT(1'b0)) u_pifb_top_small (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(s_hrdata), .hreadyout(), .hresp(), .capcomp_three_evt(cc3),
    .capcomp_four_evt(cc4), .timer_six_match(t6), .timer_four_match(t4),
    .serial_two_done(sdone), .serial_two_collision(scoll),
    .periph_irq_req(), .irq());
  pifb_event_src u_pifb_event_src (.hclk(hclk), .capcomp_three_evt(cc3),
    .capcomp_four_evt(cc4), .timer_six_match(t6), .timer_four_match(t4),
    .serial_two_done(sdone), .serial_two_collision(scoll));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // no local limit: only the watchdog ends a stuck wait
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // one single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    hsize  <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] d;
    bus(1'b1, a, {24'h00_0000, v}, d);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    chk(d, {24'h00_0000, e});
  endtask : rc

  task automatic t_reset;
    for (int i = 0; i < 7; i++) rc(12'(4 * i), 8'h00);
    chk({31'h0000_0000, periph_irq_req | irq}, 32'h0000_0000);
    rc(pifb_pkg::variant_off, 8'h01);
    chk(s_hrdata, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_events;
    logic [7:0]  eb [6] = '{8'h10, 8'h20, 8'h08, 8'h02, 8'h01, 8'h02};
    logic [11:0] a;
    for (int i = 0; i < 6; i++) begin
      a = (i < 4) ? pifb_pkg::flag_three_off : pifb_pkg::flag_four_off;
      u_pifb_event_src.pulse(i);
      rc(a, eb[i]);
      if (i >= 4) chk(s_hrdata, 32'h0000_0000);
      rc(a, eb[i]);
      wr(a, 8'h00);
      rc(a, 8'h00);
    end
  endtask : t_events

  // event lands in the data phase of a clearing write: the set must win
  task automatic t_collide;
    fork
      wr(pifb_pkg::flag_three_off, 8'h00);
      begin
        @(posedge hclk);
        u_pifb_event_src.pulse(0);
      end
    join
    rc(pifb_pkg::flag_three_off, 8'h10);
    fork
      wr(pifb_pkg::flag_four_off, 8'h00);
      begin
        @(posedge hclk);
        u_pifb_event_src.pulse(5);
      end
    join
    rc(pifb_pkg::flag_four_off, 8'h02);
    wr(pifb_pkg::flag_three_off, 8'h00);
    wr(pifb_pkg::flag_four_off, 8'h00);
  endtask : t_collide

  task automatic t_unimpl;
    wr(pifb_pkg::flag_three_off, 8'hFF);
    rc(pifb_pkg::flag_three_off, 8'h3A);
    wr(pifb_pkg::flag_four_off, 8'hFF);
    rc(pifb_pkg::flag_four_off, 8'h03);
    wr(pifb_pkg::flag_three_off, 8'h00);
    wr(pifb_pkg::flag_four_off, 8'h00);
    wr(12'h024, 8'hFF);
    rc(12'h024, 8'h00);
  endtask : t_unimpl

  // flag cleared before its enable is set, so no stale request
  task automatic t_irq;
    wr(pifb_pkg::enable_three_off, 8'h02);
    wr(pifb_pkg::irq_ctrl_off, 8'h80);
    u_pifb_event_src.pulse(3);
    rc(pifb_pkg::pending_off, 8'h00);
    wr(pifb_pkg::irq_ctrl_off, 8'hC0);
    rc(pifb_pkg::pending_off, 8'h01);
    chk({31'h0000_0000, periph_irq_req}, 32'h0000_0001);
    wr(pifb_pkg::mask_off, 8'h01);
    @(negedge hclk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rc(pifb_pkg::status_off, 8'h03);
    wr(pifb_pkg::flag_three_off, 8'h00);
    rc(pifb_pkg::pending_off, 8'h00);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(pifb_pkg::status_off, 8'h03);
    @(negedge hclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rc(pifb_pkg::status_off, 8'h00);
  endtask : t_irq

  task automatic t_rereset;
    u_pifb_event_src.pulse(5);
    u_pifb_event_src.pulse(2);
    rc(pifb_pkg::flag_three_off, 8'h08);
    rc(pifb_pkg::flag_four_off, 8'h02);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(pifb_pkg::flag_three_off, 8'h00);
    rc(pifb_pkg::flag_four_off, 8'h00);
  endtask : t_rereset

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    hresetn    = 1'b0;
    hsel       = 1'b1;
    haddr      = 12'h000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0000_0000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_events();
    t_collide();
    t_unimpl();
    t_irq();
    t_rereset();
    print_verdict();
  end
endmodule : peripheral_irq_flag_bank_tb
